// ### hdl/ufc_regs.sv
// ufc_regs: flow characters, thresholds, prescale, fill counters over APB
//
// Behaviour
// - two resume characters, read-write, reset zero
// - two halt characters, read-write, reset zero
// - status bit0 shows remote terminate
// - status bit1 shows remote transmit disable
// - bit2 sets on flow char, read clears
// - bit3 sets on special char; 7:4 zero
// - detect bits feed interrupt level six
// - transmit interrupt threshold register, reset zero
// - receive interrupt threshold register, reset zero
// - flow control low threshold, reset zero
// - flow control high threshold, reset zero
// - prescale N low nibble, M high
// - special bit6 selects receive or status count
// - receive fill count read-only, reset zero
// - line-status queue count read-only, reset zero
// - special bit7 selects transmit count or sample
// - transmit fill count read-only, reset zero
// - auto request-to-send by high/low thresholds
// - insert halt/resume chars by thresholds
`default_nettype none
module ufc_regs (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ufc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // datapath status, same clock
  input wire ufc_pkg::ufc_dp_t dp_status,
  // flow control and interrupt conditions
  output logic rts_n,
  output logic send_halt,
  output logic send_resume,
  output logic [7:0] flow_char,
  output logic rx_irq_cond,
  output logic tx_irq_cond,
  output logic char_irq,
  output logic [3:0] char_irq_level,
  // baud generator settings
  output ufc_pkg::ufc_prescale_t prescale,
  output logic [3:0] sample_clock
);
  import ufc_pkg::*;

  // programmed characters and levels
  logic [7:0] resume_char_first;
  logic [7:0] resume_char_second;
  logic [7:0] halt_char_first;
  logic [7:0] halt_char_second;
  logic [7:0] tx_irq_threshold;
  logic [7:0] rx_irq_threshold;
  logic [7:0] flow_low_threshold;
  logic [7:0] flow_high_threshold;
  logic [7:0] special_function_reg;
  logic [7:0] feature_reg;
  // read-clear detect flags and the read path
  logic flowchar_flag;
  logic special_flag;
  logic [7:0] next_rdata;
  logic known;
  // in-band flow state; gray order idle, halt, resume
  ufc_txflow_t txflow;

  // decode word index from the byte address
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[IDX_LSB +: 8];
  endfunction : reg_index

  // pick one character of a pair; mode 01 uses the second, the others the first,
  // so the reserved mode falls back to the first pair rather than to nothing
  function automatic logic [7:0] pick_char(input logic [1:0] mode, input logic [7:0] c_first,
                                           input logic [7:0] c_second);
    pick_char = (mode == TXFLOW_SECOND) ? c_second : c_first;
  endfunction : pick_char

  // a transfer counts only in its access phase; the setup cycle has no effect
  wire logic [7:0] idx = reg_index(paddr);
  wire logic access = psel & penable;
  wire logic wr = access & pwrite;
  // a status read clears the detect flags at its access edge
  wire logic rd_status = access & ~pwrite & (idx == IDX_FLOW_STATUS);
  // enhanced mode gates both automatic flow mechanisms
  wire logic enhanced = feature_reg[FEAT_ENHANCED_BIT];
  wire logic [1:0] txflow_mode = feature_reg[FEAT_TXFLOW_LO +: 2];

  // flow characters; zero-wait slave so a write lands at the access edge,
  // and any byte is accepted since the pairs are compared only downstream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_char_first <= RESET_BYTE;
      resume_char_second <= RESET_BYTE;
      halt_char_first <= RESET_BYTE;
      halt_char_second <= RESET_BYTE;
    end else if (wr) begin
      case (idx)
        IDX_RESUME_FIRST: resume_char_first <= pwdata[7:0];
        IDX_RESUME_SECOND: resume_char_second <= pwdata[7:0];
        IDX_HALT_FIRST: halt_char_first <= pwdata[7:0];
        IDX_HALT_SECOND: halt_char_second <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // interrupt and flow thresholds; no ordering between low and high is
  // enforced, so a low above high simply makes the hysteresis band empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq_threshold <= RESET_BYTE;
      rx_irq_threshold <= RESET_BYTE;
      flow_low_threshold <= RESET_BYTE;
      flow_high_threshold <= RESET_BYTE;
    end else if (wr) begin
      case (idx)
        IDX_TX_IRQ_THR: tx_irq_threshold <= pwdata[7:0];
        IDX_RX_IRQ_THR: rx_irq_threshold <= pwdata[7:0];
        IDX_FLOW_LOW: flow_low_threshold <= pwdata[7:0];
        IDX_FLOW_HIGH: flow_high_threshold <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // prescale; m codes above two are stored as written, the baud generator
  // is expected to cope, software is asked to avoid them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
    end else if (wr && idx == IDX_PRESCALE) begin
      prescale <= pwdata[7:0];
    end
  end

  // special function and feature bits select views and flow modes;
  // they change at once, a transfer in flight downstream is not waited for
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_function_reg <= RESET_BYTE;
      feature_reg <= RESET_BYTE;
    end else if (wr) begin
      case (idx)
        IDX_SPECIAL_FUNC: special_function_reg <= pwdata[7:0];
        IDX_FEATURE: feature_reg <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // sample clock shares 16h with the transmit count; only while bit7 is
  // clear does a write reach it, otherwise the write is dropped silently
  // because the count view is read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_clock <= RESET_NIBBLE;
    end else if (wr && idx == IDX_TX_COUNT && !special_function_reg[SFR_TX_SEL_BIT]) begin
      sample_clock <= pwdata[3:0];
    end
  end

  // sticky detect flags; a detect in the reading cycle survives the clear,
  // so an event in the access cycle is kept, though one landing in the setup cycle is cleared unread
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flowchar_flag <= 1'b0;
    end else begin
      flowchar_flag <= dp_status.flow_char_seen | (flowchar_flag & ~rd_status);
    end
  end

  // special-character flag follows the same set-wins rule; it is kept
  // apart so each source can be traced on its own
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_flag <= 1'b0;
    end else begin
      special_flag <= dp_status.special_char_seen | (special_flag & ~rd_status);
    end
  end

  // read mux; reserved status bits and unmapped words read zero
  // the shared words at 15h and 16h follow the special function bits,
  // and a view switch takes effect on the very next read; no read here
  // has a side effect except the status word
  always_comb begin
    next_rdata = RESET_BYTE;
    known = 1'b1;
    case (idx)
      IDX_RESUME_FIRST: next_rdata = resume_char_first;
      IDX_RESUME_SECOND: next_rdata = resume_char_second;
      IDX_HALT_FIRST: next_rdata = halt_char_first;
      IDX_HALT_SECOND: next_rdata = halt_char_second;
      IDX_FLOW_STATUS: begin
        next_rdata[ST_TERMINATE_BIT] = dp_status.remote_terminate;
        next_rdata[ST_REMOTE_DIS_BIT] = dp_status.halt_or_rts_sent;
        next_rdata[ST_FLOWCHAR_BIT] = flowchar_flag;
        next_rdata[ST_SPECIAL_BIT] = special_flag;
      end
      IDX_TX_IRQ_THR: next_rdata = tx_irq_threshold;
      IDX_RX_IRQ_THR: next_rdata = rx_irq_threshold;
      IDX_FLOW_LOW: next_rdata = flow_low_threshold;
      IDX_FLOW_HIGH: next_rdata = flow_high_threshold;
      IDX_PRESCALE: next_rdata = prescale;
      IDX_RX_COUNT: begin
        // polarity taken from the prose: bit6 set shows the receive count
        if (special_function_reg[SFR_RX_SEL_BIT]) begin
          next_rdata = dp_status.rx_fill;
        end else begin
          next_rdata = dp_status.lsq_fill;
        end
      end
      IDX_TX_COUNT: begin
        if (special_function_reg[SFR_TX_SEL_BIT]) begin
          next_rdata = dp_status.tx_fill;
        end else begin
          next_rdata = {RESET_NIBBLE, sample_clock};
        end
      end
      IDX_SPECIAL_FUNC: next_rdata = special_function_reg;
      IDX_FEATURE: next_rdata = feature_reg;
      default: known = 1'b0;
    endcase
  end

  // apb answer: ready in the first cycle of the access phase, registered, so the
  // slave never inserts wait states; a master that holds penable longer
  // sees ready only once, at the first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  // error flags an unmapped index and rides only with the ready pulse,
  // so a refused write never half-lands in a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~known;
    end
  end

  // read data is taken at the setup edge; a read-clear lands one edge later,
  // so the word shows the flags as they stood before the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= {ZERO_PAD, next_rdata};
    end
  end

  // automatic request-to-send with hysteresis: inactive (high) once the
  // fill reaches high, active again only below low; between the two
  // levels the last state holds, which keeps the pin from chattering
  // when the fill hovers around one level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n <= 1'b0;
    end else if (!(enhanced && feature_reg[FEAT_AUTO_RTS_BIT])) begin
      rts_n <= 1'b0;
    end else if (dp_status.rx_fill >= flow_high_threshold) begin
      rts_n <= 1'b1;
    end else if (dp_status.rx_fill < flow_low_threshold) begin
      rts_n <= 1'b0;
    end
  end

  // in-band transmit flow: one request pulse per threshold crossing
  // a halt is asked for only when the fill passes high, a resume only after
  // a halt, so while the flow stays enabled the remote never sees two halts without a resume between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txflow <= UFC_TXF_IDLE;
      send_halt <= 1'b0;
      send_resume <= 1'b0;
      flow_char <= RESET_BYTE;
    end else begin
      send_halt <= 1'b0;
      send_resume <= 1'b0;
      if (!enhanced || txflow_mode == TXFLOW_OFF) begin
        txflow <= UFC_TXF_IDLE;
      end else begin
        case (txflow)
          UFC_TXF_IDLE, UFC_TXF_RESUME: begin
            if (dp_status.rx_fill > flow_high_threshold) begin
              txflow <= UFC_TXF_HALT;
              send_halt <= 1'b1;
              flow_char <= pick_char(txflow_mode, halt_char_first, halt_char_second);
            end
          end
          UFC_TXF_HALT: begin
            if (dp_status.rx_fill < flow_low_threshold) begin
              txflow <= UFC_TXF_RESUME;
              send_resume <= 1'b1;
              flow_char <= pick_char(txflow_mode, resume_char_first, resume_char_second);
            end
          end
          default: txflow <= UFC_TXF_IDLE;
        endcase
      end
    end
  end

  // threshold conditions; priority encoding lives in the interrupt block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq_cond <= 1'b0;
      tx_irq_cond <= 1'b0;
    end else begin
      rx_irq_cond <= dp_status.rx_fill >= rx_irq_threshold;
      tx_irq_cond <= dp_status.tx_fill <= tx_irq_threshold;
    end
  end

  // character-detect source at its fixed level; the feature bit masks it,
  // while the status flags themselves keep recording events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      char_irq <= 1'b0;
      char_irq_level <= RESET_NIBBLE;
    end else begin
      char_irq <= feature_reg[FEAT_HALT_IRQ_BIT] & (flowchar_flag | special_flag);
      char_irq_level <= IRQ_LEVEL_CHAR;
    end
  end
endmodule : ufc_regs
`default_nettype wire

// ### hdl/ufc_pkg.sv
// ufc_pkg: register map, field layout and carrier types of the flow register group
`default_nettype none
package ufc_pkg;
  // register indices; printed offsets are not all multiples of four, byte address = 4 * index
  localparam logic [7:0] IDX_RESUME_FIRST = 8'h0B;
  localparam logic [7:0] IDX_RESUME_SECOND = 8'h0C;
  localparam logic [7:0] IDX_HALT_FIRST = 8'h0D;
  localparam logic [7:0] IDX_HALT_SECOND = 8'h0E;
  localparam logic [7:0] IDX_FLOW_STATUS = 8'h0F;
  localparam logic [7:0] IDX_TX_IRQ_THR = 8'h10;
  localparam logic [7:0] IDX_RX_IRQ_THR = 8'h11;
  localparam logic [7:0] IDX_FLOW_LOW = 8'h12;
  localparam logic [7:0] IDX_FLOW_HIGH = 8'h13;
  localparam logic [7:0] IDX_PRESCALE = 8'h14;
  localparam logic [7:0] IDX_RX_COUNT = 8'h15;
  localparam logic [7:0] IDX_TX_COUNT = 8'h16;
  // registers of our own: special function, enhanced features, sample clock
  localparam logic [7:0] IDX_SPECIAL_FUNC = 8'h07;
  localparam logic [7:0] IDX_FEATURE = 8'h02;
  localparam logic [7:0] IDX_SAMPLE_CLOCK = 8'h18;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  // field positions
  localparam int SFR_RX_SEL_BIT = 6;
  localparam int SFR_TX_SEL_BIT = 7;
  localparam int FEAT_TXFLOW_LO = 2;
  localparam int FEAT_ENHANCED_BIT = 4;
  localparam int FEAT_SPECIAL_BIT = 5;
  localparam int FEAT_AUTO_RTS_BIT = 6;
  localparam int FEAT_HALT_IRQ_BIT = 7;
  localparam int ST_TERMINATE_BIT = 0;
  localparam int ST_REMOTE_DIS_BIT = 1;
  localparam int ST_FLOWCHAR_BIT = 2;
  localparam int ST_SPECIAL_BIT = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_NIBBLE = 4'h0;
  localparam logic [23:0] ZERO_PAD = 24'h000000;
  localparam logic [1:0] TXFLOW_OFF = 2'h0;
  localparam logic [1:0] TXFLOW_SECOND = 2'h1;
  // interrupt priority level for the character-detect source
  localparam logic [3:0] IRQ_LEVEL_CHAR = 4'h6;

  typedef struct packed {
    logic [3:0] m_field;
    logic [3:0] n_field;
  } ufc_prescale_t;

  // datapath view presented to this register group
  typedef struct packed {
    logic [7:0] rx_fill;
    logic [7:0] lsq_fill;
    logic [7:0] tx_fill;
    logic remote_terminate;
    logic flow_char_seen;
    logic special_char_seen;
    logic halt_or_rts_sent;
  } ufc_dp_t;

  typedef enum logic [1:0] {
    UFC_TXF_IDLE = 2'b00,
    UFC_TXF_HALT = 2'b01,
    UFC_TXF_RESUME = 2'b11
  } ufc_txflow_t;
endpackage : ufc_pkg
`default_nettype wire

// ### tb/ufc_dp_model.sv
// ufc_dp_model: datapath stand-in presenting fill levels and detect pulses
`default_nettype none
module ufc_dp_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels and events asked for by the bench
  input wire logic [7:0] rx,
  input wire logic [7:0] lsq,
  input wire logic [7:0] tx,
  input wire logic term,
  input wire logic sent,
  input wire logic fl,
  input wire logic sp,
  // status view into the register group
  output var ufc_pkg::ufc_dp_t dp
);
  import ufc_pkg::*;
  // one register stage like the real datapath, so every change lands a cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dp <= '0;
    else dp <= '{rx, lsq, tx, term, fl, sp, sent};
  end
endmodule : ufc_dp_model
`default_nettype wire

// ### tb/ufc_regs_assertions.sv
// ufc_regs_assertions: apb and register checks bound to ufc_regs
`default_nettype none
module ufc_regs_assertions (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ufc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // flow and settings
  input wire logic send_halt,
  input wire logic send_resume,
  input wire logic [3:0] char_irq_level,
  input wire ufc_pkg::ufc_prescale_t prescale
);
  import ufc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [7:0] idx = paddr[9:2];
  // setup cycle and finished read, the steps the access checks start from
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence read_s;
    pready && !pwrite;
  endsequence
  ready_one_a: assert property (setup_s |=> pready) else $error("pready late");
  ready_access_a: assert property (pready |-> psel && penable) else $error("pready idle");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  upper_zero_a: assert property (read_s |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  reserved_zero_a: assert property (read_s ##0 idx == IDX_FLOW_STATUS |-> prdata[7:4] == 4'h0)
    else $error("status bits 7:4 set");
  level_six_a: assert property ($past(presetn) |-> char_irq_level == IRQ_LEVEL_CHAR)
    else $error("irq level not six");
  prescale_write_a: assert property (
    !$stable(prescale) |-> $past(pready && pwrite && idx == IDX_PRESCALE))
    else $error("prescale moved without write");
  halt_pulse_a: assert property (send_halt |=> !send_halt) else $error("halt pulse long");
  pulse_excl_a: assert property (!(send_halt && send_resume)) else $error("both chars");
endmodule : ufc_regs_assertions
bind ufc_regs ufc_regs_assertions ufc_regs_assertions_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .send_halt, .send_resume, .char_irq_level,
  .prescale);
`default_nettype wire

// ### tb/ufc_regs_tb.sv
// ufc_regs_tb: self-checking bench for the flow register group
`default_nettype none
module ufc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ufc_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic term = 1'h0, sent = 1'h0, fl = 1'h0, sp = 1'h0, pready, pslverr, rts_n, er;
  logic send_halt, send_resume, rx_irq_cond, tx_irq_cond, char_irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [7:0] rx = 8'h00, lsq = 8'h00, tx = 8'h00, flow_char, v, sh [8'h0B:8'h16];
  logic [7:0] lv [5] = '{8'h1F, 8'h20, 8'h21, 8'h08, 8'h07};
  logic [3:0] char_irq_level, sample_clock, sc;
  ufc_dp_t dp_status;
  ufc_prescale_t prescale;
  int bad_count = 0, check_count = 0, cyc = 0, nh, ns;
  always #10 pclk = ~pclk;
  // cuts a hung handshake short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  ufc_dp_model ufc_dp_model_i (.pclk, .presetn, .rx, .lsq, .tx, .term, .sent, .fl, .sp,
    .dp(dp_status));
  ufc_regs ufc_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dp_status, .rts_n, .send_halt, .send_resume, .flow_char, .rx_irq_cond,
    .tx_irq_cond, .char_irq, .char_irq_level, .prescale, .sample_clock);
  task summarize;
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; upper data bits are random since only the low byte counts
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    r = $urandom;
    r[7:0] = d;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= r;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task rchk(input string nm, input logic [7:0] i, input logic [7:0] e);
    apb(1'h0, i, 8'h00);
    chk(nm, e, rd[7:0]);
  endtask : rchk
  task ev(input logic s);
    @(posedge pclk);
    fl <= !s;
    sp <= s;
    @(posedge pclk);
    fl <= 1'h0;
    sp <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask : ev
  function logic ro(input int i);
    return i inside {IDX_FLOW_STATUS, IDX_RX_COUNT, IDX_TX_COUNT};
  endfunction : ro
  function logic [7:0] exp_st(input logic f, input logic s);
    return {4'h0, s, f, sent, term};
  endfunction : exp_st
  initial begin
    v = 8'($urandom(32'hC98F));
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 8'h0B; i <= 8'h16; i++) rchk("reset", 8'(i), 8'h00);
    // random bytes, prescale M kept to its safe codes
    foreach (sh[i]) begin
      sh[i] = 8'($urandom);
      if (i == IDX_PRESCALE) sh[i][7:4] = 4'($urandom_range(2));
      if (!ro(i)) apb(1'h1, 8'(i), sh[i]);
    end
    foreach (sh[i]) if (!ro(i)) rchk("rw", 8'(i), sh[i]);
    chk("prescale", sh[IDX_PRESCALE], prescale);
    // detect bits: set by events, cleared by reading, masked by the feature bit
    apb(1'h1, IDX_FLOW_STATUS, 8'hFF);
    apb(1'h1, IDX_FEATURE, 8'h80);
    term <= 1'h1;
    ev(1'h0);
    chk("char_irq", 8'h01, 8'(char_irq));
    rchk("status", IDX_FLOW_STATUS, exp_st(1'h1, 1'h0));
    rchk("status", IDX_FLOW_STATUS, exp_st(1'h0, 1'h0));
    chk("char_irq", 8'h00, 8'(char_irq));
    apb(1'h1, IDX_FEATURE, 8'h00);
    term <= 1'h0;
    sent <= 1'h1;
    ev(1'h1);
    chk("char_irq", 8'h00, 8'(char_irq));
    rchk("status", IDX_FLOW_STATUS, exp_st(1'h0, 1'h1));
    // count views; writes at 16h land only while it is the sample clock
    rx <= 8'($urandom);
    lsq <= 8'($urandom);
    tx <= 8'($urandom);
    for (int s = 0; s < 4; s++) begin
      apb(1'h1, IDX_SPECIAL_FUNC, 8'(s << 6));
      v = 8'($urandom);
      apb(1'h1, IDX_TX_COUNT, v);
      if (s < 2) sc = v[3:0];
      rchk("rx_count", IDX_RX_COUNT, s[0] ? rx : lsq);
      rchk("tx_count", IDX_TX_COUNT, s[1] ? tx : {4'h0, sc});
      chk("sample_clock", {4'h0, sc}, {4'h0, sample_clock});
    end
    apb(1'h0, 8'h30, 8'h00);
    chk("pslverr", 8'h01, 8'(er));
    chk("unmapped", 8'h00, rd[7:0]);
    // fill levels one below, at and one above each interrupt threshold
    for (int k = -1; k < 2; k++) begin
      rx <= sh[IDX_RX_IRQ_THR] + 8'(k);
      tx <= sh[IDX_TX_IRQ_THR] + 8'(k);
      repeat (4) @(posedge pclk);
      chk("rx_irq", 8'(rx >= sh[IDX_RX_IRQ_THR]), 8'(rx_irq_cond));
      chk("tx_irq", 8'(tx <= sh[IDX_TX_IRQ_THR]), 8'(tx_irq_cond));
    end
    // fill walks past high then below low: rts hysteresis and inserted chars
    rx <= 8'h00;
    apb(1'h1, IDX_FLOW_HIGH, 8'h20);
    apb(1'h1, IDX_FLOW_LOW, 8'h08);
    apb(1'h1, IDX_FEATURE, 8'h74);
    for (int j = 0; j < 5; j++) begin
      rx <= lv[j];
      nh = 0;
      ns = 0;
      repeat (6) begin
        @(posedge pclk);
        if (send_halt === 1'h1) begin
          nh++;
          chk("halt_char", sh[IDX_HALT_SECOND], flow_char);
        end
        if (send_resume === 1'h1) begin
          ns++;
          chk("resume_char", sh[IDX_RESUME_SECOND], flow_char);
        end
      end
      chk("rts_n", 8'(j > 0 && j < 4), 8'(rts_n));
      chk("halts", 8'(j == 2), 8'(nh));
      chk("resumes", 8'(j == 4), 8'(ns));
    end
    // first-character mode: climbing past high again inserts the first halt char
    apb(1'h1, IDX_FEATURE, 8'h78);
    rx <= 8'h21;
    nh = 0;
    repeat (6) begin
      @(posedge pclk);
      if (send_halt === 1'h1) begin
        nh++;
        chk("halt_first", sh[IDX_HALT_FIRST], flow_char);
      end
    end
    chk("halts_first", 8'h01, 8'(nh));
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rchk("prescale", IDX_PRESCALE, 8'h00);
    summarize();
  end
endmodule : ufc_regs_tb
`default_nettype wire
